/* File: include/fault_ctrl_defs.vh */
/*
  register offsets, field positions, reset values and command codes of the
  cable driver control register bank. assumes nothing of its surroundings.
*/
`ifndef FAULT_CTRL_DEFS_VH
`define FAULT_CTRL_DEFS_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define OFS_POLARITY 8'h03
`define OFS_HD_AMP 8'h04
`define OFS_LOSS_CTRL 8'h05
`define OFS_RESERVED_A_A 8'h06
`define OFS_RESERVED_A_B 8'h07
`define OFS_CMP_CMD 8'h08
`define OFS_POS_COUNT 8'h0A
`define OFS_NEG_COUNT 8'h0B

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RST_POLARITY 8'hC0
`define RST_HD_AMP 8'h90
`define RST_LOSS_CTRL 8'h02
`define RST_CMP_CMD 8'h00
`define RST_THRESHOLD 4'h9
`define RST_DRIVE_LEVEL 5'h10

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define BIT_HD_LSB 7
`define BIT_SD_LSB 6
`define BIT_NEG_POL 2
`define BIT_POS_POL 1
`define BIT_DET_POL 0
`define BIT_FORCE_ABSENT 6
`define BIT_FORCE_PRESENT 5
`define BIT_POWER_LINK 4
`define BIT_MUTE_SEL 3
`define FLD_HD_UPPER 7:5
`define FLD_DRIVE_LEVEL 4:0
`define FLD_SD_UPPER 2:0
`define FLD_CMD 7:5
`define MSK_POLARITY 8'hC7
`define MSK_LOSS_CTRL 8'h7F
`define MSK_CMP_CMD 8'hE0

// ------------------------------------------------------------
// compare commands and counter bounds
// ------------------------------------------------------------
`define CMD_CURRENT_MAX 3'b000
`define CMD_CAPTURE_POS 3'b001
`define CMD_CAPTURE_NEG 3'b010
`define CMD_RESET_MIN 3'b101
`define CNT_FLOOR 5'h00
`define CNT_CEIL 5'h1F

`endif

/* File: core/peak_tracker.v */
/*
  one termination-fault counter peak tracker: follows max or min of a 5-bit
  counter. assumes the counter input is already synchronous to clk_sys.
*/
`timescale 1ns/1ps
`include "fault_ctrl_defs.vh"

module peak_tracker #(
  parameter WIDTH = 5
) (
  input wire clk_sys,
  input wire rst,
  input wire reset_max,
  input wire reset_min,
  input wire track_min,
  input wire [WIDTH-1:0] count,
  output reg [WIDTH-1:0] peak_q
);

  always @(posedge clk_sys) begin
    if (rst) begin
      peak_q <= `CNT_FLOOR;
    end else if (reset_max) begin
      peak_q <= `CNT_FLOOR;
    end else if (reset_min) begin
      peak_q <= `CNT_CEIL;
    end else if (track_min ? (count < peak_q) : (count > peak_q)) begin
      peak_q <= count;
    end
  end

endmodule // peak_tracker

/* File: core/cable_driver_fault_output_ctrl.v */
/*
  control register bank of a serial video cable driver: thresholds, fault
  pin polarity, amplitude, signal-loss behaviour and peak compare commands.
  assumes an smbus engine elsewhere presents single-cycle register strobes
  on clk_sys, and that pin/analog status inputs may be asynchronous.
*/
`timescale 1ns/1ps
`include "fault_ctrl_defs.vh"

// Summary of operation
// [R1] hd rate threshold is output bits 7:5 over polarity bit 7, reset 1001
// [R2] sd rate threshold is control bits 2:0 over polarity bit 6, reset 0101
// [R3] negative fault polarity 0 flags on error 1, polarity 1 on error 0
// [R4] positive fault polarity 0 flags on error 1, polarity 1 on error 0
// [R5] detect polarity 0 flags on signal absent, 1 flags on signal present
// [R6] five-bit drive level code in output bits 4:0, reset 10000
// [R7] force-absent holds output muted or offset per mute select unless force-present is set
// [R8] force-present never mutes nor offsets the output
// [R9] overrides never change the reported signal-detect status bit
// [R10] power link ties output power down to enable, detect and power bit
// [R11] signal loss adds offset when mute select 0, mutes when 1
// [R12] command 000 resets compare to 00, shows current counts, tracks max
// [R13] command 001 shows positive counter peak, 010 negative counter peak
// [R14] command 101 resets compare to 1f and tracks minimum
// [R15] host never writes reserved compare command codes
// [R16] host writes zeros to all reserved fields
// [R17] signal-detect status reads 1 when valid input is present
// [R18] a masked condition never pulls the fault pin low
// [R19] counter readback returns current or captured peak per command
// [R20] fault pin low when any unmasked condition is active, else high
module cable_driver_fault_output_ctrl #(
  parameter CNT_W = 5
) (
  input wire clk_sys,
  input wire rst,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_q,
  output reg reg_hit_q,
  input wire sd_rate_select,
  input wire output_stage_off,
  input wire enable_pin,
  input wire mask_neg_term,
  input wire mask_pos_term,
  input wire mask_signal,
  input wire neg_term_error,
  input wire pos_term_error,
  input wire input_signal_present,
  input wire [CNT_W-1:0] pos_term_count,
  input wire [CNT_W-1:0] neg_term_count,
  output reg fault_n_q,
  output reg status_signal_q,
  output reg [3:0] term_threshold_q,
  output reg [4:0] drive_level_code_q,
  output reg cable_output_mute_q,
  output reg cable_output_offset_q,
  output reg cable_output_powered_down_q
);

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  reg [2:0] sync1_q;
  reg [2:0] sync2_q;
  reg [CNT_W-1:0] pos_cnt1_q;
  reg [CNT_W-1:0] pos_cnt2_q;
  reg [CNT_W-1:0] neg_cnt1_q;
  reg [CNT_W-1:0] neg_cnt2_q;
  reg [CNT_W-1:0] pos_cnt3_q;
  reg [CNT_W-1:0] neg_cnt3_q;
  reg [CNT_W-1:0] pos_cnt_q;
  reg [CNT_W-1:0] neg_cnt_q;
  reg [1:0] pin1_q;
  reg [1:0] pin2_q;

  // each stage pair settles single bits only; whole count words are filtered below
  always @(posedge clk_sys) begin
    if (rst) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      pos_cnt1_q <= {CNT_W{1'b0}};
      pos_cnt2_q <= {CNT_W{1'b0}};
      neg_cnt1_q <= {CNT_W{1'b0}};
      neg_cnt2_q <= {CNT_W{1'b0}};
    end else begin
      sync1_q <= {neg_term_error, pos_term_error, input_signal_present};
      sync2_q <= sync1_q;
      pos_cnt1_q <= pos_term_count;
      pos_cnt2_q <= pos_cnt1_q;
      neg_cnt1_q <= neg_term_count;
      neg_cnt2_q <= neg_cnt1_q;
    end
  end

  wire neg_err = sync2_q[2];
  wire pos_err = sync2_q[1];
  wire sig_present = sync2_q[0];

  // a count word is taken only when two samples in a row agree, so a word caught
  // between two values is never shown nor tracked; a count that moves on every
  // clock stays at its last steady value
  always @(posedge clk_sys) begin
    if (rst) begin
      pos_cnt3_q <= {CNT_W{1'b0}};
      neg_cnt3_q <= {CNT_W{1'b0}};
      pos_cnt_q <= {CNT_W{1'b0}};
      neg_cnt_q <= {CNT_W{1'b0}};
    end else begin
      pos_cnt3_q <= pos_cnt2_q;
      neg_cnt3_q <= neg_cnt2_q;
      if (pos_cnt2_q == pos_cnt3_q) begin
        pos_cnt_q <= pos_cnt2_q;
      end
      if (neg_cnt2_q == neg_cnt3_q) begin
        neg_cnt_q <= neg_cnt2_q;
      end
    end
  end

  // enable and rate select are pins; enable resets high so that reset is not
  // followed by a false power-down pulse
  always @(posedge clk_sys) begin
    if (rst) begin
      pin1_q <= 2'h2;
      pin2_q <= 2'h2;
    end else begin
      pin1_q <= {enable_pin, sd_rate_select};
      pin2_q <= pin1_q;
    end
  end

  wire enable_sync = pin2_q[1];
  wire sd_sync = pin2_q[0];

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg [7:0] polarity_q;
  reg [7:0] hd_amp_q;
  reg [7:0] loss_ctrl_q;
  reg [7:0] cmp_cmd_q;
  reg cmd_strobe_q;

  always @(posedge clk_sys) begin
    if (rst) begin
      polarity_q <= `RST_POLARITY;
      hd_amp_q <= `RST_HD_AMP;
      loss_ctrl_q <= `RST_LOSS_CTRL;
      cmp_cmd_q <= `RST_CMP_CMD;
      cmd_strobe_q <= 1'b0;
    end else begin
      cmd_strobe_q <= 1'b0;
      if (reg_wr) begin
        case (reg_addr)
          `OFS_POLARITY: begin
            polarity_q <= reg_wdata & `MSK_POLARITY;
          end
          // [R6] amplitude code
          `OFS_HD_AMP: begin
            hd_amp_q <= reg_wdata;
          end
          `OFS_LOSS_CTRL: begin
            loss_ctrl_q <= reg_wdata & `MSK_LOSS_CTRL;
          end
          // [R15] reserved codes are stored but cause no action
          `OFS_CMP_CMD: begin
            cmp_cmd_q <= reg_wdata & `MSK_CMP_CMD;
            cmd_strobe_q <= 1'b1;
          end
          default: begin
          end
        endcase
      end
    end
  end

  wire [2:0] cmd = cmp_cmd_q[`FLD_CMD];

  // ------------------------------------------------------------
  // peak compare
  // ------------------------------------------------------------
  reg track_min_q;
  wire pos_to_max;
  wire pos_to_min;
  wire [CNT_W-1:0] pos_peak;
  wire [CNT_W-1:0] neg_peak;

  // [R12] [R14] compare reset and peak direction
  assign pos_to_max = cmd_strobe_q && (cmd == `CMD_CURRENT_MAX);
  assign pos_to_min = cmd_strobe_q && (cmd == `CMD_RESET_MIN);

  always @(posedge clk_sys) begin
    if (rst) begin
      track_min_q <= 1'b0;
    end else if (pos_to_max) begin
      track_min_q <= 1'b0;
    end else if (pos_to_min) begin
      track_min_q <= 1'b1;
    end
  end

  peak_tracker #(
    .WIDTH(CNT_W)
  ) u_pos_peak (
    .clk_sys(clk_sys),
    .rst(rst),
    .reset_max(pos_to_max),
    .reset_min(pos_to_min),
    .track_min(track_min_q),
    .count(pos_cnt_q),
    .peak_q(pos_peak)
  );

  peak_tracker #(
    .WIDTH(CNT_W)
  ) u_neg_peak (
    .clk_sys(clk_sys),
    .rst(rst),
    .reset_max(pos_to_max),
    .reset_min(pos_to_min),
    .track_min(track_min_q),
    .count(neg_cnt_q),
    .peak_q(neg_peak)
  );

  // [R13] [R19] readback selects captured peak or current count
  wire [CNT_W-1:0] pos_show = (cmd == `CMD_CAPTURE_POS) ? pos_peak : pos_cnt_q;
  wire [CNT_W-1:0] neg_show = (cmd == `CMD_CAPTURE_NEG) ? neg_peak : neg_cnt_q;

  // ------------------------------------------------------------
  // register read
  // ------------------------------------------------------------
  reg [7:0] rdata_d;
  reg hit_d;

  always @* begin
    hit_d = 1'b1;
    case (reg_addr)
      `OFS_POLARITY: rdata_d = polarity_q;
      `OFS_HD_AMP: rdata_d = hd_amp_q;
      `OFS_LOSS_CTRL: rdata_d = loss_ctrl_q;
      `OFS_RESERVED_A_A: rdata_d = 8'h00;
      `OFS_RESERVED_A_B: rdata_d = 8'h00;
      `OFS_CMP_CMD: rdata_d = cmp_cmd_q;
      `OFS_POS_COUNT: rdata_d = {{(8-CNT_W){1'b0}}, pos_show};
      `OFS_NEG_COUNT: rdata_d = {{(8-CNT_W){1'b0}}, neg_show};
      default: begin
        rdata_d = 8'h00;
        hit_d = 1'b0;
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata_q <= 8'h00;
      reg_hit_q <= 1'b0;
    end else if (reg_rd) begin
      reg_rdata_q <= rdata_d;
      reg_hit_q <= hit_d;
    end
  end

  // ------------------------------------------------------------
  // fault pin and output control
  // ------------------------------------------------------------
  // [R3] negative fault polarity
  wire neg_active = polarity_q[`BIT_NEG_POL] ? ~neg_err : neg_err;
  // [R4] positive fault polarity
  wire pos_active = polarity_q[`BIT_POS_POL] ? ~pos_err : pos_err;
  // [R5] detect polarity
  wire det_active = polarity_q[`BIT_DET_POL] ? sig_present : ~sig_present;

  // [R18] [R20] masked conditions are dropped before the or
  wire any_fault = (neg_active & ~mask_neg_term) | (pos_active & ~mask_pos_term) |
    (det_active & ~mask_signal);

  // [R8] [R7] overrides act only on the output path, force-present wins
  wire effective_loss = ~loss_ctrl_q[`BIT_FORCE_PRESENT] &
    (loss_ctrl_q[`BIT_FORCE_ABSENT] | ~sig_present);

  // [R10] power link
  wire power_down_d = ~enable_sync | output_stage_off |
    (loss_ctrl_q[`BIT_POWER_LINK] & ~sig_present);

  wire [3:0] threshold_d = sd_sync ?
    {loss_ctrl_q[`FLD_SD_UPPER], polarity_q[`BIT_SD_LSB]} :
    {hd_amp_q[`FLD_HD_UPPER], polarity_q[`BIT_HD_LSB]};

  always @(posedge clk_sys) begin
    if (rst) begin
      fault_n_q <= 1'b1;
      status_signal_q <= 1'b0;
      term_threshold_q <= `RST_THRESHOLD;
      drive_level_code_q <= `RST_DRIVE_LEVEL;
      cable_output_mute_q <= 1'b0;
      cable_output_offset_q <= 1'b0;
      cable_output_powered_down_q <= 1'b0;
    end else begin
      fault_n_q <= ~any_fault;
      // [R9] [R17] status shows the true detect level
      status_signal_q <= sig_present;
      // [R1] [R2] threshold by rate
      term_threshold_q <= threshold_d;
      drive_level_code_q <= hd_amp_q[`FLD_DRIVE_LEVEL];
      // [R11] mute or offset on loss
      cable_output_mute_q <= effective_loss & loss_ctrl_q[`BIT_MUTE_SEL];
      cable_output_offset_q <= effective_loss & ~loss_ctrl_q[`BIT_MUTE_SEL];
      cable_output_powered_down_q <= power_down_d;
    end
  end

endmodule // cable_driver_fault_output_ctrl

/* File: bench/cable_driver_fault_output_ctrl_sva.sv */
/* checker for the cable driver control bank.
   assumes it is bound to the bank and sees only its ports. */
`timescale 1ns/1ps
module cable_driver_fault_output_ctrl_sva (
  input wire clk_sys,
  input wire rst,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_rdata_q,
  input wire reg_hit_q,
  input wire output_stage_off,
  input wire enable_pin,
  input wire mask_neg_term,
  input wire mask_pos_term,
  input wire mask_signal,
  input wire input_signal_present,
  input wire fault_n_q,
  input wire status_signal_q,
  input wire [4:0] drive_level_code_q,
  input wire cable_output_mute_q,
  input wire cable_output_offset_q,
  input wire cable_output_powered_down_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_amp_rst; $fell(rst) |-> drive_level_code_q == 5'h10 && fault_n_q; endproperty
  a_amp_rst: assert property (p_amp_rst) else $error("amp reset");
  // a write reaches the amplitude output two edges later
  property p_amp_wr;
    $changed(drive_level_code_q) |-> $past(reg_wr, 2) && $past(reg_addr, 2) == 8'h04;
  endproperty
  a_amp_wr: assert property (p_amp_wr) else $error("amp change");
  property p_stat_hi; input_signal_present [*3] |=> status_signal_q; endproperty
  a_stat_hi: assert property (p_stat_hi) else $error("status low");
  property p_stat_lo; !input_signal_present [*3] |=> !status_signal_q; endproperty
  a_stat_lo: assert property (p_stat_lo) else $error("status high");
  property p_masked;
    (mask_neg_term && mask_pos_term && mask_signal) [*4] |=> fault_n_q;
  endproperty
  a_masked: assert property (p_masked) else $error("masked fault");
  property p_en_off; !enable_pin [*4] |=> cable_output_powered_down_q; endproperty
  a_en_off: assert property (p_en_off) else $error("enable off");
  property p_pres_on;
    (enable_pin && !output_stage_off && input_signal_present) [*4]
      |=> !cable_output_powered_down_q;
  endproperty
  a_pres_on: assert property (p_pres_on) else $error("powered down");
  property p_excl; !(cable_output_mute_q && cable_output_offset_q); endproperty
  a_excl: assert property (p_excl) else $error("mute and offset");
  property p_cnt; reg_rd && reg_addr[7:1] == 7'h05 |=> reg_rdata_q[7:5] == 3'h0 && reg_hit_q;
  endproperty
  a_cnt: assert property (p_cnt) else $error("count read");
  c_cmd: cover property (reg_wr && reg_addr == 8'h08);
  c_fault: cover property ($fell(fault_n_q));
  c_pd: cover property ($rose(cable_output_powered_down_q));
endmodule // cable_driver_fault_output_ctrl_sva

bind cable_driver_fault_output_ctrl cable_driver_fault_output_ctrl_sva chk (
  .clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_rdata_q(reg_rdata_q), .reg_hit_q(reg_hit_q), .output_stage_off(output_stage_off),
  .enable_pin(enable_pin), .mask_neg_term(mask_neg_term), .mask_pos_term(mask_pos_term),
  .mask_signal(mask_signal), .input_signal_present(input_signal_present),
  .fault_n_q(fault_n_q), .status_signal_q(status_signal_q),
  .drive_level_code_q(drive_level_code_q), .cable_output_mute_q(cable_output_mute_q),
  .cable_output_offset_q(cable_output_offset_q),
  .cable_output_powered_down_q(cable_output_powered_down_q)
);

/* File: bench/smbus_host_model.sv */
/* host model driving the register strobes.
   assumes the bank takes a strobe on the rising edge of clk_sys. */
`timescale 1ns/1ps
module smbus_host_model (
  input wire clk_sys,
  input wire [7:0] reg_rdata_q,
  input wire reg_hit_q,
  output reg reg_wr,
  output reg reg_rd,
  output reg [7:0] reg_addr,
  output reg [7:0] reg_wdata
);
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0_0000;
  end
  // released lines carry the inverse so a stale value cannot pass
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge clk_sys);
      reg_addr = a;
      reg_wdata = d & (a == 8'h03 ? 8'hc7 : a == 8'h05 ? 8'h7f : a == 8'h08 ? 8'he0 :
        a[7:1] == 7'h03 ? 8'h00 : 8'hff);
      reg_wr = 1'b1;
      @(negedge clk_sys);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~reg_wdata;
    end
  endtask
  task rd(input [7:0] a, output [7:0] d, output h);
    begin
      @(negedge clk_sys);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk_sys);
      reg_rd = 1'b0;
      reg_addr = ~a;
      @(negedge clk_sys);
      d = reg_rdata_q;
      h = reg_hit_q;
    end
  endtask
endmodule // smbus_host_model

/* File: bench/test_cable_driver_fault_output_ctrl.sv */
/* self-checking bench for the cable driver control bank.
   assumes the host model and bound checker are compiled first. */
`timescale 1ns/1ps
module test_cable_driver_fault_output_ctrl;
  reg clk_sys = 1'b0, rst = 1'b1, sd = 1'b0, pd = 1'b0, en = 1'b1, sig = 1'b1;
  reg mn = 1'b0, mp = 1'b0, ms = 1'b0, ne = 1'b0, pe = 1'b0, h;
  reg [4:0] pc = 5'h00, nc = 5'h00;
  reg [31:0] rn;
  reg [7:0] r3, r4, r5, d;
  integer seed = 28, n_errors = 0, n_tests = 0, i;
  wire reg_wr, reg_rd, reg_hit_q, fault_n_q, status_signal_q, mute, offs, pdn;
  wire [7:0] reg_addr, reg_wdata, reg_rdata_q;
  wire [3:0] thr;
  wire [4:0] drive_level_code;
  initial forever #2 clk_sys = ~clk_sys;
  cable_driver_fault_output_ctrl #(.CNT_W(5)) dut (
    .clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .reg_hit_q(reg_hit_q),
    .sd_rate_select(sd), .output_stage_off(pd), .enable_pin(en), .mask_neg_term(mn),
    .mask_pos_term(mp), .mask_signal(ms), .neg_term_error(ne), .pos_term_error(pe),
    .input_signal_present(sig), .pos_term_count(pc), .neg_term_count(nc),
    .fault_n_q(fault_n_q), .status_signal_q(status_signal_q), .term_threshold_q(thr),
    .drive_level_code_q(drive_level_code), .cable_output_mute_q(mute), .cable_output_offset_q(offs),
    .cable_output_powered_down_q(pdn)
  );
  smbus_host_model host (
    .clk_sys(clk_sys), .reg_rdata_q(reg_rdata_q), .reg_hit_q(reg_hit_q), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata)
  );
  function fault_f(input [2:0] pol, input [2:0] msk, input [2:0] flg);
    fault_f = ~|(~msk & (flg ^ {pol[2:1], ~pol[0]}));
  endfunction
  // force-present beats force-absent
  function [2:0] loss_f(input [7:0] c, input s, input e, input p);
    reg l;
    begin
      l = !c[5] && (c[6] || !s);
      loss_f = {l & c[3], l & ~c[3], ~e | p | (c[4] & ~s)};
    end
  endfunction
  task check(input [7:0] got, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task settle;
    repeat (5) @(negedge clk_sys);
  endtask
  task rdchk(input [7:0] a, input [7:0] e);
    begin
      host.rd(a, d, h);
      check(d, e);
    end
  endtask
  task close_out;
    begin
      $display("tests %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    #20000;
    n_errors = n_errors + 1;
    close_out;
  end
  initial begin
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    rdchk(8'h03, 8'hc0);
    rdchk(8'h04, 8'h90);
    rdchk(8'h05, 8'h02);
    rdchk(8'h08, 8'h00);
    rdchk(8'h07, 8'h00);
    check({7'h00, reg_hit_q}, 8'h01);
    rdchk(8'h20, 8'h00);
    check({7'h00, h}, 8'h00);
    check({4'h0, thr}, 8'h09);
    sd = 1'b1;
    settle;
    check({4'h0, thr}, 8'h05);
    $display("reset values done");
    for (i = 0; i < 24; i = i + 1) begin
      rn = $random(seed);
      r3 = rn[7:0];
      r4 = rn[15:8];
      r5 = (i < 4) ? {1'b0, i[1:0], rn[20:16]} : rn[31:24];
      host.wr(8'h03, r3);
      host.wr(8'h04, r4);
      host.wr(8'h05, r5);
      rn = $random(seed);
      // one condition unmasked at a time, then all masked
      {sd, pd, en, mn, mp, ms, ne, pe, sig} =
        (i < 4) ? {rn[8:6], ~(3'b100 >> i), rn[2:0]} : rn[8:0];
      settle;
      check({4'h0, thr}, sd ? {r5[2:0], r3[6]} : {r4[7:5], r3[7]});
      check({3'h0, drive_level_code}, {3'h0, r4[4:0]});
      check({7'h00, fault_n_q}, {7'h00, fault_f(r3[2:0], {mn, mp, ms}, {ne, pe, sig})});
      check({5'h00, mute, offs, pdn}, {5'h00, loss_f(r5, sig, en, pd)});
      check({7'h00, status_signal_q}, {7'h00, sig});
      rdchk(8'h05, r5 & 8'h7f);
    end
    $display("config sweep done");
    pc = 5'h0c;
    nc = 5'h03;
    settle;
    host.wr(8'h08, 8'ha0);
    settle;
    pc = 5'h04;
    nc = 5'h0b;
    settle;
    pc = 5'h0a;
    host.wr(8'h08, 8'h20);
    settle;
    rdchk(8'h0a, 8'h04);
    rdchk(8'h0b, 8'h0b);
    host.wr(8'h08, 8'h40);
    settle;
    rdchk(8'h0b, 8'h03);
    rdchk(8'h0a, 8'h0a);
    pc = 5'h06;
    settle;
    host.wr(8'h08, 8'h00);
    settle;
    pc = 5'h02;
    settle;
    rdchk(8'h0a, 8'h02);
    host.wr(8'h08, 8'h20);
    settle;
    rdchk(8'h0a, 8'h06);
    $display("peak compare done");
    close_out;
  end
endmodule // test_cable_driver_fault_output_ctrl
